// *** design/lsd_regs.vh ***
// Register offsets, field positions, reset values and level codes of the segment LCD driver
`ifndef LSD_REGS_VH
`define LSD_REGS_VH

`define LSD_ADDR_CTRL1      8'h00
`define LSD_ADDR_CTRL2      8'h04
`define LSD_ADDR_POWER      8'h08
`define LSD_ADDR_STATUS     8'h0c
`define LSD_ADDR_RAM0       8'h40
`define LSD_ADDR_RAM3       8'h4c

`define LSD_C1_ACT          0
`define LSD_C1_DISP         1
`define LSD_C1_DUTY_LO      2
`define LSD_C1_DUTY_HI      3
`define LSD_C1_BOOST        4
`define LSD_C1_EXPAND       5
`define LSD_C1_SGS_LO       8
`define LSD_C1_SGS_HI       11
`define LSD_C1_CKS_LO       12
`define LSD_C1_CKS_HI       15
`define LSD_CTRL1_RESET     16'h0000

`define LSD_C2_WAVE         7
`define LSD_C2_SRC          4
`define LSD_C2_CDS_LO       0
`define LSD_C2_CDS_HI       3
`define LSD_C2_RSV_ONES     8'h60
`define LSD_CTRL2_RESET     8'h60

`define LSD_PW_SWITCH       0
`define LSD_POWER_RESET     1'b0

`define LSD_ST_PHASE        0
`define LSD_ST_COM_LO       1
`define LSD_ST_COM_HI       2
`define LSD_ST_LADDER       3
`define LSD_ST_RUN          4

`define LSD_DUTY_STATIC     2'h0
`define LSD_DUTY_HALF       2'h1
`define LSD_DUTY_THIRD      2'h2
`define LSD_DUTY_QUARTER    2'h3

`define LSD_LVL_VSS         2'h0
`define LSD_LVL_V3          2'h1
`define LSD_LVL_V2          2'h2
`define LSD_LVL_V1          2'h3

`define LSD_CDS_ALWAYS      4'h0
`define LSD_CDS_NEVER       4'h7

`endif

// *** design/lsd_ram.v ***
// Display RAM: byte-strobed write port, two registered read ports
`timescale 1ns/1ps
module lsd_ram #(
    parameter AW = 2,
    parameter DW = 32
) (
    input  wire          mclk,
    input  wire          arst_n,
    input  wire          we,
    input  wire [DW/8-1:0] wstrb,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr_a,
    output reg  [DW-1:0] rdata_a_ff,
    input  wire [AW-1:0] raddr_b,
    output reg  [DW-1:0] rdata_b_ff
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    always @(posedge mclk)
    begin
        for (i = 0; i < DW/8; i = i + 1)
        begin
            if (we && wstrb[i])
                mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_a_ff <= {DW{1'b0}};
            rdata_b_ff <= {DW{1'b0}};
        end
        else
        begin
            rdata_a_ff <= mem[raddr_a];
            rdata_b_ff <= mem[raddr_b];
        end
    end
endmodule // lsd_ram

// *** design/lsd_ctrl.v ***
// Segment LCD controller/driver: APB registers, scan timing, level select, ladder gating
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "lsd_regs.vh"

// Functional notes
// RULE1: Boost with static duty drives one common waveform on all four commons.
// RULE2: Boost with half duty: wave one on commons 1-2, wave two on 3-4.
// RULE3: Two-bit duty field picks static, half, third or quarter duty.
// RULE4: Four-bit segment field enables chosen segment drivers only; others undriven.
// RULE5: Four-bit frame clock field sets the frame rate.
// RULE6: Waveform bit chooses A-type or B-type drive waveform.
// RULE7: External bias: software selects main supply and switches drive supply off.
// RULE8: RAM-to-pin mapping depends on duty and on segment expansion.
// RULE9: Display RAM takes byte or word writes; software fills the duty's part.
// RULE10: Once configured and switched on, scanning runs without further trigger.
// RULE11: Drive-source bit set runs the boosted supply; cleared stops it.
// RULE12: Ladder connects while charging, disconnects while discharging; panel stays driven.
// RULE13: Four-bit charge-duty field sets charge versus discharge proportion.
// RULE14: Levels chosen from data, phase and duty per the level table.
// RULE15: Waveform bit 0 is A-type, 1 is B-type, reset value 0.
// RULE16: Frame clock: subclock /1, /2, /4 or system clock /2 to /256.
// RULE17: Charge codes: 0 always, 1-6 eighths, 7 never, 10xx 1/16, 11xx 1/32.
// RULE18: Phase toggles at frame boundaries so the panel sees no DC.
module lsd_ctrl #(
    parameter NSEG = 32
) (
    input  wire              mclk,
    input  wire              arst_n,
    input  wire              sub_clk_tick,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata_ff,
    output reg               pready_ff,
    output reg               pslverr_ff,
    output reg  [7:0]        com_lvl_ff,
    output reg  [2*NSEG-1:0] seg_lvl_ff,
    output reg  [NSEG-1:0]   seg_oe_ff,
    output reg               ladder_connect_ff,
    output reg               boost_supply_en_ff,
    output reg               drive_power_en_ff,
    output reg               ext_data_ff,
    output reg               ext_clk_ff,
    output reg               ext_m_ff
);
    localparam ST_OFF = 2'b01;
    localparam ST_RUN = 2'b10;

    reg  [15:0]       ctrl1_ff;
    reg  [7:0]        ctrl2_ff;
    reg               power_sw_ff;
    reg  [1:0]        state_ff;
    reg  [1:0]        nxt_state;
    reg  [7:0]        sys_div_ff;
    reg  [1:0]        sub_div_ff;
    reg  [1:0]        com_idx_ff;
    reg               half_ff;
    reg               phase_ff;
    reg  [4:0]        cd_cnt_ff;
    reg  [NSEG-1:0]   shift_ff;
    reg  [5:0]        shift_cnt_ff;
    reg  [31:0]       nxt_prdata;
    reg               nxt_err;
    reg  [7:0]        nxt_com_lvl;
    reg  [2*NSEG-1:0] nxt_seg_lvl;
    reg  [NSEG-1:0]   nxt_seg_oe;
    reg               sel;
    integer           k;

    wire        act       = ctrl1_ff[`LSD_C1_ACT];
    wire        disp      = ctrl1_ff[`LSD_C1_DISP];
    wire [1:0]  duty      = ctrl1_ff[`LSD_C1_DUTY_HI:`LSD_C1_DUTY_LO];
    wire        boost     = ctrl1_ff[`LSD_C1_BOOST];
    wire        expand    = ctrl1_ff[`LSD_C1_EXPAND];
    wire [3:0]  sgs       = ctrl1_ff[`LSD_C1_SGS_HI:`LSD_C1_SGS_LO];
    wire [3:0]  cks       = ctrl1_ff[`LSD_C1_CKS_HI:`LSD_C1_CKS_LO];
    wire        wave_b    = ctrl2_ff[`LSD_C2_WAVE];
    wire [3:0]  cds       = ctrl2_ff[`LSD_C2_CDS_HI:`LSD_C2_CDS_LO];
    wire        access    = psel && penable && !pready_ff;
    wire        done      = psel && penable && pready_ff;
    wire        ram_hit   = paddr >= `LSD_ADDR_RAM0 && paddr <= `LSD_ADDR_RAM3;
    wire        ram_we    = done && pwrite && ram_hit;
    wire [31:0] ram_rd_a;
    wire [31:0] row;
    wire        run       = state_ff == ST_RUN;
    wire        sys_tick;
    wire        sub_tick;
    wire        frame_tick;

    // RULE9: byte lanes follow pstrb, so bytes and words both land
    lsd_ram #(
        .AW (2),
        .DW (32)
    ) i_lsd_ram (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .we         (ram_we),
        .wstrb      (pstrb),
        .waddr      (paddr[3:2]),
        .wdata      (pwdata),
        .raddr_a    (paddr[3:2]),
        .rdata_a_ff (ram_rd_a),
        .raddr_b    (com_idx_ff),
        .rdata_b_ff (row)
    );

    // RULE14: common level from selection, phase and duty
    function [1:0] com_level;
        input       s;
        input       m;
        input [1:0] d;
        begin
            if (d == `LSD_DUTY_STATIC || s)
                com_level = m ? `LSD_LVL_VSS : `LSD_LVL_V1;
            else if (d == `LSD_DUTY_HALF)
                com_level = `LSD_LVL_V2;
            else
                com_level = m ? `LSD_LVL_V2 : `LSD_LVL_V3;
        end
    endfunction

    // RULE14: segment level from data, phase and duty
    function [1:0] seg_level;
        input       dat;
        input       m;
        input [1:0] d;
        begin
            if (dat)
                seg_level = m ? `LSD_LVL_V1 : `LSD_LVL_VSS;
            else if (d == `LSD_DUTY_STATIC || d == `LSD_DUTY_HALF)
                seg_level = m ? `LSD_LVL_VSS : `LSD_LVL_V1;
            else
                seg_level = m ? `LSD_LVL_V3 : `LSD_LVL_V2;
        end
    endfunction

    // RULE17: charge window within a 32-tick gating cycle
    function charge_on;
        input [3:0] c;
        input [4:0] n;
        begin
            if (c == `LSD_CDS_ALWAYS)
                charge_on = 1'b1;
            else if (c == `LSD_CDS_NEVER)
                charge_on = 1'b0;
            else if (!c[3])
                charge_on = n[2:0] < c[2:0];
            else if (!c[2])
                charge_on = n[3:0] == 4'h0;
            else
                charge_on = n == 5'h00;
        end
    endfunction

    // RULE16: system clock divided by 2 to 256
    assign sys_tick = (sys_div_ff & ((8'h02 << cks[2:0]) - 8'h01))
                      == ((8'h02 << cks[2:0]) - 8'h01);
    assign sub_tick = sub_clk_tick && (cks[1] ? sub_div_ff == 2'h3 :
                      cks[0] ? sub_div_ff[0] : 1'b1);
    // RULE5: field picks the tick source and divide ratio
    assign frame_tick = cks[3] ? sys_tick : sub_tick;

    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:
                // RULE10: switching on starts the scan by itself
                if (act)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (!act)
                    nxt_state = ST_OFF;
            default:
                nxt_state = ST_OFF;
        endcase
    end

    always @*
    begin
        nxt_err    = !(ram_hit || paddr == `LSD_ADDR_CTRL1 || paddr == `LSD_ADDR_CTRL2
                     || paddr == `LSD_ADDR_POWER || paddr == `LSD_ADDR_STATUS);
        nxt_prdata = 32'h0000_0000;
        if (ram_hit)
            nxt_prdata = ram_rd_a;
        else if (paddr == `LSD_ADDR_CTRL1)
            nxt_prdata = {16'h0000, ctrl1_ff};
        else if (paddr == `LSD_ADDR_CTRL2)
            nxt_prdata = {24'h00_0000, ctrl2_ff | `LSD_C2_RSV_ONES};
        else if (paddr == `LSD_ADDR_POWER)
            nxt_prdata = {31'h0000_0000, power_sw_ff};
        else if (paddr == `LSD_ADDR_STATUS)
            nxt_prdata = {27'h000_0000, run, ladder_connect_ff, com_idx_ff, phase_ff};
    end

    always @*
    begin
        nxt_com_lvl = 8'h00;
        nxt_seg_lvl = {2*NSEG{1'b0}};
        nxt_seg_oe  = {NSEG{1'b0}};
        sel         = 1'b0;
        for (k = 0; k < 4; k = k + 1)
        begin
            // RULE1: static boost copies the first common everywhere
            if (boost && duty == `LSD_DUTY_STATIC)
                sel = 1'b1;
            // RULE2: half boost pairs commons 1-2 and 3-4
            else if (boost && duty == `LSD_DUTY_HALF)
                sel = (k[2:1] == {1'b0, com_idx_ff[0]});
            else
                sel = (k[1:0] == com_idx_ff);
            if (run)
                nxt_com_lvl[2*k +: 2] = com_level(sel, phase_ff, duty);
        end
        for (k = 0; k < NSEG; k = k + 1)
        begin
            // RULE4: first 4*n segments enabled; expansion frees all of them
            nxt_seg_oe[k] = !expand && (sgs[3] || k < {sgs[2:0], 2'b00});
            // RULE8: row word picked by common index, bit by segment
            if (run)
                nxt_seg_lvl[2*k +: 2] = seg_level(disp && row[k], phase_ff, duty);
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl1_ff    <= `LSD_CTRL1_RESET;
            ctrl2_ff    <= `LSD_CTRL2_RESET;
            power_sw_ff <= `LSD_POWER_RESET;
            prdata_ff   <= 32'h0000_0000;
            pready_ff   <= 1'b0;
            pslverr_ff  <= 1'b0;
        end
        else
        begin
            pready_ff  <= access;
            pslverr_ff <= access && nxt_err;
            if (access && !pwrite)
                prdata_ff <= nxt_prdata;
            if (done && pwrite && paddr == `LSD_ADDR_CTRL1)
            begin
                if (pstrb[0])
                    ctrl1_ff[7:0] <= pwdata[7:0];
                if (pstrb[1])
                    ctrl1_ff[15:8] <= pwdata[15:8];
            end
            // RULE15: waveform bit lives here and resets to A-type
            if (done && pwrite && paddr == `LSD_ADDR_CTRL2 && pstrb[0])
                ctrl2_ff <= (pwdata[7:0] & 8'h9f) | `LSD_C2_RSV_ONES;
            if (done && pwrite && paddr == `LSD_ADDR_POWER && pstrb[0])
                power_sw_ff <= pwdata[`LSD_PW_SWITCH];
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff   <= ST_OFF;
            sys_div_ff <= 8'h00;
            sub_div_ff <= 2'h0;
            com_idx_ff <= 2'h0;
            half_ff    <= 1'b0;
            phase_ff   <= 1'b0;
            cd_cnt_ff  <= 5'h00;
        end
        else
        begin
            state_ff   <= nxt_state;
            sys_div_ff <= sys_div_ff + 8'h01;
            if (sub_clk_tick)
                sub_div_ff <= sub_div_ff + 2'h1;
            if (!run)
            begin
                com_idx_ff <= 2'h0;
                half_ff    <= 1'b0;
                phase_ff   <= 1'b0;
            end
            else if (frame_tick)
            begin
                cd_cnt_ff <= cd_cnt_ff + 5'h01;
                // RULE6: A-type flips phase every half slot, B-type once per frame
                if (!wave_b)
                begin
                    phase_ff <= ~phase_ff;
                    half_ff  <= ~half_ff;
                end
                if (wave_b || half_ff)
                begin
                    // RULE3: common count follows the duty field
                    if (com_idx_ff == duty)
                    begin
                        com_idx_ff <= 2'h0;
                        // RULE18: B-type reverses polarity at each frame boundary
                        if (wave_b)
                            phase_ff <= ~phase_ff;
                    end
                    else
                        com_idx_ff <= com_idx_ff + 2'h1;
                end
            end
        end
    end

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            com_lvl_ff         <= 8'h00;
            seg_lvl_ff         <= {2*NSEG{1'b0}};
            seg_oe_ff          <= {NSEG{1'b0}};
            ladder_connect_ff  <= 1'b0;
            boost_supply_en_ff <= 1'b0;
            drive_power_en_ff  <= 1'b0;
        end
        else
        begin
            com_lvl_ff <= nxt_com_lvl;
            seg_lvl_ff <= nxt_seg_lvl;
            seg_oe_ff  <= nxt_seg_oe;
            // RULE12: ladder gated while the level outputs keep running
            // RULE13: proportion set by the charge-duty field
            ladder_connect_ff  <= run && charge_on(cds, cd_cnt_ff);
            // RULE11: boosted supply follows the drive-source bit
            boost_supply_en_ff <= ctrl2_ff[`LSD_C2_SRC];
            // RULE7: software clears the switch when an external bias is fitted
            drive_power_en_ff  <= power_sw_ff;
        end
    end

    // Serial feed to an external expander; restarts on each frame tick, so slow ticks only
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shift_ff     <= {NSEG{1'b0}};
            shift_cnt_ff <= 6'h00;
            ext_data_ff  <= 1'b0;
            ext_clk_ff   <= 1'b0;
            ext_m_ff     <= 1'b0;
        end
        else if (!(run && expand))
        begin
            shift_cnt_ff <= 6'h00;
            ext_clk_ff   <= 1'b0;
            ext_m_ff     <= 1'b0;
        end
        else
        begin
            ext_m_ff <= phase_ff;
            // RULE8: with expansion the row goes out serially from segment one
            if (frame_tick)
            begin
                shift_ff     <= disp ? row : {NSEG{1'b0}};
                shift_cnt_ff <= NSEG[5:0];
                ext_clk_ff   <= 1'b0;
            end
            else if (shift_cnt_ff != 6'h00)
            begin
                ext_clk_ff <= ~ext_clk_ff;
                if (ext_clk_ff)
                begin
                    shift_ff     <= shift_ff >> 1;
                    shift_cnt_ff <= shift_cnt_ff - 6'h01;
                end
                else
                    ext_data_ff <= shift_ff[0];
            end
            else
                ext_clk_ff <= 1'b0;
        end
    end
endmodule // lsd_ctrl

// *** test/lsd_ctrl_sva.sv ***
// Port-level assertion checker for the segment LCD driver
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_ctrl_sva #(
    parameter NSEG = 32
) (
    input wire              mclk,
    input wire              arst_n,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [7:0]        paddr,
    input wire [31:0]       pwdata,
    input wire [3:0]        pstrb,
    input wire              pready_ff,
    input wire              pslverr_ff,
    input wire [7:0]        com_lvl_ff,
    input wire [2*NSEG-1:0] seg_lvl_ff,
    input wire [NSEG-1:0]   seg_oe_ff,
    input wire              ladder_connect_ff,
    input wire              boost_supply_en_ff,
    input wire              drive_power_en_ff
);
    // Shadow of the settings; display and supply outputs judged only once a write has settled, APB handshake every cycle
    reg  [15:0]     c1_ff;
    reg  [7:0]      c2_ff;
    reg             pw_ff;
    reg  [2:0]      age_ff;
    wire            wr = psel && penable && pwrite && pready_ff;
    wire            ok = (age_ff == 3'h7);
    wire [1:0]      duty = c1_ff[3:2];
    wire [3:0]      sgs = c1_ff[11:8];
    wire [3:0]      csel = {~^com_lvl_ff[7:6], ~^com_lvl_ff[5:4],
                            ~^com_lvl_ff[3:2], ~^com_lvl_ff[1:0]};
    wire [NSEG-1:0] oe_exp = c1_ff[`LSD_C1_EXPAND] ? {NSEG{1'b0}} :
                             (sgs[3] ? {NSEG{1'b1}} : ({NSEG{1'b1}} >> (NSEG - 4 * sgs)));

    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            c1_ff  <= `LSD_CTRL1_RESET;
            c2_ff  <= `LSD_CTRL2_RESET;
            pw_ff  <= `LSD_POWER_RESET;
            age_ff <= 3'h0;
        end
        else
        begin
            age_ff <= wr ? 3'h0 : (ok ? age_ff : age_ff + 3'h1);
            if (wr && paddr == `LSD_ADDR_CTRL1 && pstrb[0])
                c1_ff[7:0] <= pwdata[7:0];
            if (wr && paddr == `LSD_ADDR_CTRL1 && pstrb[1])
                c1_ff[15:8] <= pwdata[15:8];
            if (wr && paddr == `LSD_ADDR_CTRL2 && pstrb[0])
                c2_ff <= pwdata[7:0] | `LSD_C2_RSV_ONES;
            if (wr && paddr == `LSD_ADDR_POWER && pstrb[0])
                pw_ff <= pwdata[0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    ready_wait_a: assert property (
        psel && penable && !pready_ff |=> pready_ff) else $error("access not answered");
    ready_pulse_a: assert property (
        pready_ff |-> psel && penable ##1 !pready_ff) else $error("ready outside access");
    bad_addr_a: assert property (
        pready_ff |-> pslverr_ff == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
        8'h40, 8'h44, 8'h48, 8'h4c})) else $error("error flag wrong");
    static_boost_a: assert property (
        ok && c1_ff[0] && c1_ff[4] && duty == `LSD_DUTY_STATIC |-> com_lvl_ff[1:0] ==
        com_lvl_ff[3:2] && com_lvl_ff[5:4] == com_lvl_ff[7:6] && com_lvl_ff[1:0] ==
        com_lvl_ff[5:4]) else $error("static boost commons differ");
    half_boost_a: assert property (
        ok && c1_ff[0] && c1_ff[4] && duty == `LSD_DUTY_HALF |-> com_lvl_ff[1:0] ==
        com_lvl_ff[3:2] && com_lvl_ff[5:4] == com_lvl_ff[7:6]) else $error("half boost pairs");
    one_common_a: assert property (
        ok && c1_ff[0] && duty[1] |-> (duty[0] ? $onehot(csel) : $onehot(csel[2:0])))
        else $error("selected common count");
    seg_enable_a: assert property (
        ok |-> seg_oe_ff == oe_exp) else $error("segment enables wrong");
    boost_supply_a: assert property (
        ok |-> boost_supply_en_ff == c2_ff[`LSD_C2_SRC]) else $error("boost supply wrong");
    drive_power_a: assert property (
        ok |-> drive_power_en_ff == pw_ff) else $error("drive power wrong");
    stopped_vss_a: assert property (
        ok && !c1_ff[0] |-> com_lvl_ff == 8'h00 && seg_lvl_ff == '0) else $error("not VSS");
    ladder_never_a: assert property (
        ok && c2_ff[3:0] == `LSD_CDS_NEVER |-> !ladder_connect_ff) else $error("ladder on");
    ladder_always_a: assert property (
        ok && c1_ff[0] && c2_ff[3:0] == `LSD_CDS_ALWAYS |-> ladder_connect_ff)
        else $error("ladder off");
endmodule // lsd_ctrl_sva

bind lsd_ctrl lsd_ctrl_sva #(.NSEG(NSEG)) i_lsd_ctrl_sva (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .com_lvl_ff(com_lvl_ff), .seg_lvl_ff(seg_lvl_ff),
    .seg_oe_ff(seg_oe_ff), .ladder_connect_ff(ladder_connect_ff),
    .boost_supply_en_ff(boost_supply_en_ff), .drive_power_en_ff(drive_power_en_ff));

// *** test/lsd_panel.sv ***
// Passive panel model: two pixels on common 1, DC and drive energy totals
`timescale 1ns/1ps
module lsd_panel (
    input  wire       mclk,
    input  wire       clr,
    input  wire [1:0] com_lvl,
    input  wire [3:0] seg_lvl,
    input  wire [1:0] seg_oe,
    input  wire       half,
    output integer    dc_on,
    output integer    dc_off,
    output integer    rms_on,
    output integer    rms_off
);
    integer d_on;
    integer d_off;

    // Doubled volts; V2 and V3 tied at mid-rail in half duty
    function automatic integer volt(input logic [1:0] c, input logic h);
        return (c == 2'h3) ? 6 : (c == 2'h0) ? 0 : h ? 3 : 2 * c;
    endfunction

    // Undriven segment carries no field across its pixel
    always @*
    begin
        d_on  = seg_oe[0] ? volt(com_lvl, half) - volt(seg_lvl[1:0], half) : 0;
        d_off = seg_oe[1] ? volt(com_lvl, half) - volt(seg_lvl[3:2], half) : 0;
    end

    always @(posedge mclk)
    begin
        dc_on   <= clr ? 0 : dc_on + d_on;
        dc_off  <= clr ? 0 : dc_off + d_off;
        rms_on  <= clr ? 0 : rms_on + d_on * d_on;
        rms_off <= clr ? 0 : rms_off + d_off * d_off;
    end
endmodule // lsd_panel

// *** test/tb_lcd_segment_driver_control.sv ***
// Self-checking bench for the segment LCD driver
`timescale 1ns/1ps
`include "lsd_regs.vh"
module tb_lcd_segment_driver_control;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sub_clk_tick = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        clr = 1'b1;
    logic [31:0] rd;
    logic        rd_err;
    logic [1:0]  prev;
    wire  [31:0] prdata_ff;
    wire  [7:0]  com_lvl_ff;
    wire  [63:0] seg_lvl_ff;
    wire  [31:0] seg_oe_ff;
    wire         pready_ff, pslverr_ff, ladder_connect_ff, boost_supply_en_ff, drive_power_en_ff;
    integer      dc_on, dc_off, rms_on, rms_off, i, chg, lad;
    integer      err_count = 0;
    integer      checked = 0;
    integer      tick_cnt = 0;

    lsd_ctrl i_lsd_ctrl (.mclk(mclk), .arst_n(arst_n), .sub_clk_tick(sub_clk_tick),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .com_lvl_ff(com_lvl_ff), .seg_lvl_ff(seg_lvl_ff), .seg_oe_ff(seg_oe_ff),
        .ladder_connect_ff(ladder_connect_ff), .boost_supply_en_ff(boost_supply_en_ff),
        .drive_power_en_ff(drive_power_en_ff), .ext_data_ff(), .ext_clk_ff(), .ext_m_ff());
    lsd_panel i_lsd_panel (.mclk(mclk), .clr(clr), .half(i / 2 == 1), .com_lvl(com_lvl_ff[1:0]),
        .seg_lvl(seg_lvl_ff[3:0]), .seg_oe(seg_oe_ff[1:0]), .dc_on(dc_on), .dc_off(dc_off),
        .rms_on(rms_on), .rms_off(rms_off));

    always #50 mclk = ~mclk;

    // Subclock every 80 cycles, slow enough for the expander shift
    always @(posedge mclk)
    begin
        tick_cnt     <= (tick_cnt == 79) ? 0 : tick_cnt + 1;
        sub_clk_tick <= (tick_cnt == 79);
    end

    task automatic complete_run;
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        integer n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= wr ? s : 4'h0;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready_ff !== 1'b1 && n < 16);
        rd      = prdata_ff;
        rd_err  = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready_ff !== 1'b1)
        begin
            err_count++;
            complete_run;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        check(rd, exp);
    endtask

    task automatic idle(input integer n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic measure(input integer n);
        chg  = 0;
        lad  = 0;
        prev = com_lvl_ff[1:0];
        repeat (n)
        begin
            @(posedge mclk);
            chg += (com_lvl_ff[1:0] != prev);
            lad += ladder_connect_ff;
            prev = com_lvl_ff[1:0];
        end
    endtask

    function automatic integer exp_lad(input integer c);
        if (c == 0)
            return 2560;
        if (c == 7)
            return 0;
        if (c < 7)
            return c * 320;
        return (c < 12) ? 160 : 80;
    endfunction

    initial
    begin
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        rd_chk(`LSD_ADDR_CTRL1, 32'h0);
        rd_chk(`LSD_ADDR_CTRL2, 32'h60);
        rd_chk(`LSD_ADDR_POWER, 32'h0);
        apb(1'b1, `LSD_ADDR_CTRL2, 32'hff, 4'hf);
        rd_chk(`LSD_ADDR_CTRL2, 32'hff);
        apb(1'b1, `LSD_ADDR_CTRL2, 32'h00, 4'hf);
        rd_chk(`LSD_ADDR_CTRL2, 32'h60);
        rd_chk(8'h10, 32'h0);
        check(rd_err, 1'b1);
        apb(1'b1, `LSD_ADDR_RAM0, 32'h12345678, 4'hf);
        apb(1'b1, `LSD_ADDR_RAM0, 32'h0000ab00, 4'h2);
        rd_chk(`LSD_ADDR_RAM0, 32'h1234ab78);
        apb(1'b1, `LSD_ADDR_POWER, 32'h1, 4'hf);
        apb(1'b1, `LSD_ADDR_CTRL2, 32'h10, 4'hf);
        idle(8);
        check({drive_power_en_ff, boost_supply_en_ff}, 2'b11);
        apb(1'b1, `LSD_ADDR_CTRL2, 32'h0, 4'hf);
        apb(1'b1, `LSD_ADDR_POWER, 32'h0, 4'hf);
        idle(8);
        check({drive_power_en_ff, boost_supply_en_ff}, 2'b00);
        for (i = 0; i <= 8; i++)
        begin
            apb(1'b1, `LSD_ADDR_CTRL1, i << 8, 4'hf);
            idle(8);
            check(seg_oe_ff, (i == 8) ? 32'hffffffff : (32'h1 << (4 * i)) - 1);
        end
        apb(1'b1, `LSD_ADDR_CTRL1, 32'h0820, 4'hf);
        idle(8);
        check(seg_oe_ff, 32'h0);
        apb(1'b1, `LSD_ADDR_RAM0, 32'h1, 4'hf);
        for (i = 1; i < 4; i++)
            apb(1'b1, `LSD_ADDR_RAM0 + 4 * i, 32'h0, 4'hf);
        for (i = 0; i < 8; i++)
        begin
            apb(1'b1, `LSD_ADDR_CTRL2, (i % 2) << 7, 4'hf);
            apb(1'b1, `LSD_ADDR_CTRL1, 32'h0813 | ((i / 2) << 2), 4'hf);
            idle(300);
            clr <= 1'b0;
            idle(1920);
            clr <= 1'b1;
            #1;
            check(dc_on, 0);
            check(dc_off, 0);
            check(rms_on > rms_off, 1'b1);
        end
        apb(1'b1, `LSD_ADDR_CTRL2, 32'h0, 4'hf);
        for (i = 0; i < 16; i++)
        begin
            apb(1'b1, `LSD_ADDR_CTRL1, 32'h0803 | (i << 12), 4'hf);
            idle(400);
            measure(1280);
            check(chg, i[3] ? 1280 >> (i[2:0] + 1) : (i[1] ? 4 : (i[0] ? 8 : 16)));
        end
        apb(1'b1, `LSD_ADDR_CTRL1, 32'h0803, 4'hf);
        for (i = 0; i < 16; i++)
        begin
            apb(1'b1, `LSD_ADDR_CTRL2, i, 4'hf);
            idle(100);
            measure(2560);
            check(lad, exp_lad(i));
            check(chg, 32);
        end
        complete_run;
    end
endmodule // tb_lcd_segment_driver_control
